// ==== core/ivfc_top.sv ====
// input-rail fault command registers and overvoltage response sequencer
`timescale 1ns/1ns
module ivfc_top #(
    parameter int HALF_MS_CYCLES = ivfc_pkg::TON_STEP_CYCLES
) (
    // clocks and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pwm_clk,
    // command port
    input wire ivfc_pkg::ivfc_cmd_t cmd,
    output ivfc_pkg::ivfc_rsp_t rsp_q,
    // nonvolatile restore
    input wire logic nvm_restore,
    input wire logic [10:0] nvm_ov_man,
    input wire logic [10:0] nvm_uv_man,
    input wire logic [10:0] nvm_ton_man,
    input wire logic [7:0] nvm_resp,
    // converter
    input wire logic [15:0] vin_meas,
    input wire logic enable,
    input wire logic [7:0] rise_ticks,
    input wire logic clear_faults,
    output logic switching_q,
    output logic ramp_start_q,
    output logic latched_off_q,
    output ivfc_pkg::ivfc_stat_t status_q
);
    import ivfc_pkg::*;

    generate
        if (HALF_MS_CYCLES < 2 || HALF_MS_CYCLES > 65535) begin : g_bad
            $error("HALF_MS_CYCLES out of range");
        end
    endgenerate

    function automatic logic signed [31:0] lin_q8(input logic [15:0] w);
        logic signed [31:0] m;
        int sh;
        m = {{21{w[MAN_MSB]}}, w[MAN_MSB:0]};
        sh = int'($signed(w[EXP_MSB:EXP_LSB])) + FRAC_BITS;
        if (sh >= 0) begin
            return m <<< sh;
        end
        return m >>> (-sh);
    endfunction

    function automatic logic volt_ok(input logic signed [31:0] v);
        return (v >= V_MIN_Q8) && (v <= V_MAX_Q8);
    endfunction

    function automatic logic [15:0] round_grid(input logic signed [31:0] v, input int shift,
                                               input logic signed [31:0] lo,
                                               input logic signed [31:0] hi,
                                               input logic [4:0] e);
        logic signed [31:0] s;
        s = (v + (32'sd1 <<< (shift - 1))) >>> shift;
        if (s < lo) begin
            s = lo;
        end
        if (s > hi) begin
            s = hi;
        end
        return {e, s[MAN_MSB:0]};
    endfunction

    function automatic logic [3:0] dly_cycles(input logic [2:0] code);
        if (code <= 3'h1) begin
            return DLY_SHORT;
        end
        if (code <= 3'h4) begin
            return DLY_MID;
        end
        return DLY_LONG;
    endfunction

    logic [15:0] ov_lim_q;
    logic [7:0] resp_q;
    logic [15:0] uv_lim_q;
    logic [15:0] ton_q;
    logic restore_q;
    logic uv_programmed_q;
    ivfc_state_t st_q;
    logic [2:0] attempts_q;
    logic [15:0] pre_q;
    logic [11:0] wait_q;
    logic dly_req_q;
    logic [3:0] dly_cnt_q;
    logic dly_done_raw;
    logic dly_done_s;
    logic ov_prev_q;
    logic uv_prev_q;

    logic signed [31:0] vin_q8;
    logic signed [31:0] wr_q8;
    logic ov_present;
    logic uv_present;
    logic ov_rise;
    logic uv_rise;
    logic wr_ov;
    logic wr_resp;
    logic wr_uv;
    logic wr_ton;
    logic wr_ov_ok;
    logic wr_resp_ok;
    logic wr_uv_ok;
    logic wr_ton_ok;
    logic wr_err;
    logic tick;
    logic [1:0] act;
    logic [2:0] retry;
    logic [2:0] dcode;
    logic [11:0] restart_wait_period_ticks;
    logic signed [31:0] ton_q8;

    assign act = resp_q[ACT_MSB:ACT_LSB];
    assign retry = resp_q[RETRY_MSB:RETRY_LSB];
    assign dcode = resp_q[DLY_MSB:0];
    // codes 0 and 1 both wait one rise time
    // widened before the product so a long rise time cannot wrap
    assign restart_wait_period_ticks = 12'(dcode == 3'h0 ? 3'h1 : dcode) * 12'(rise_ticks);
    assign ton_q8 = lin_q8(ton_q);

    // thresholds compared in volts with eight fraction bits
    assign vin_q8 = {16'h0000, vin_meas};
    assign ov_present = vin_q8 > lin_q8(ov_lim_q);
    assign uv_present = vin_q8 < lin_q8(uv_lim_q);
    assign ov_rise = ov_present && !ov_prev_q;
    assign uv_rise = uv_present && !uv_prev_q;

    assign wr_q8 = lin_q8(cmd.wdata);
    assign wr_ov = cmd.valid && cmd.write && cmd.code == CODE_OV_LIMIT;
    assign wr_resp = cmd.valid && cmd.write && cmd.code == CODE_OV_RESP;
    assign wr_uv = cmd.valid && cmd.write && cmd.code == CODE_UV_LIMIT;
    assign wr_ton = cmd.valid && cmd.write && cmd.code == CODE_TURN_ON_DELAY;
    assign wr_ov_ok = volt_ok(wr_q8) && wr_q8[OV_STEP_SHIFT-1:0] == '0;
    assign wr_resp_ok = cmd.wdata[ACT_MSB:ACT_LSB] != ACT_INVALID;
    // the 5 V floor also keeps a raised warning from dropping back
    assign wr_uv_ok = volt_ok(wr_q8);
    assign wr_ton_ok = wr_q8 >= 0 && wr_q8 <= TON_MAX_Q8
                       && wr_q8[TON_STEP_SHIFT-1:0] == '0;
    assign wr_err = (wr_ov && !wr_ov_ok) || (wr_resp && !wr_resp_ok)
                    || (wr_uv && !wr_uv_ok) || (wr_ton && !wr_ton_ok);

    // restore runs once after reset and on each nonvolatile reload
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            restore_q <= 1'b1;
        end else begin
            restore_q <= nvm_restore;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ov_lim_q <= {EXP_QUARTER, 11'h000};
            uv_lim_q <= {EXP_QUARTER, UV_RESET_MAN};
            ton_q <= {EXP_HALF, 11'h000};
            resp_q <= 8'h00;
            uv_programmed_q <= 1'b0;
        end else if (restore_q) begin
            ov_lim_q <= round_grid(lin_q8({EXP_QUARTER, nvm_ov_man}), OV_STEP_SHIFT,
                                   OV_MIN_STEPS, OV_MAX_STEPS, EXP_QUARTER);
            uv_lim_q <= {EXP_QUARTER, nvm_uv_man};
            ton_q <= round_grid(lin_q8({EXP_HALF, nvm_ton_man}), TON_STEP_SHIFT,
                                32'sd0, TON_MAX_STEPS, EXP_HALF);
            resp_q <= nvm_resp;
        end else begin
            if (wr_ov && wr_ov_ok) begin
                ov_lim_q <= cmd.wdata;
            end
            if (wr_resp && wr_resp_ok) begin
                resp_q <= cmd.wdata[7:0];
            end
            if (wr_uv && wr_uv_ok) begin
                uv_lim_q <= cmd.wdata;
                uv_programmed_q <= 1'b1;
            end
            if (wr_ton && wr_ton_ok) begin
                ton_q <= cmd.wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid <= cmd.valid;
            rsp_q.err <= 1'b0;
            rsp_q.rdata <= 16'h0000;
            if (cmd.valid && cmd.write) begin
                rsp_q.err <= wr_err;
            end else if (cmd.valid && cmd.code == CODE_OV_LIMIT) begin
                rsp_q.rdata <= ov_lim_q;
            end else if (cmd.valid && cmd.code == CODE_OV_RESP) begin
                rsp_q.rdata <= {8'h00, resp_q};
            end else if (cmd.valid && cmd.code == CODE_UV_LIMIT) begin
                rsp_q.rdata <= uv_lim_q;
            end else if (cmd.valid && cmd.code == CODE_TURN_ON_DELAY) begin
                rsp_q.rdata <= ton_q;
            end else if (cmd.valid) begin
                rsp_q.err <= 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ov_prev_q <= 1'b0;
            uv_prev_q <= 1'b0;
        end else begin
            ov_prev_q <= ov_present;
            uv_prev_q <= uv_present;
        end
    end

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_q <= '0;
        end else begin
            if (clear_faults) begin
                status_q <= '0;
            end
            if (ov_rise) begin
                status_q.none_above <= 1'b1;
                status_q.input_flag <= 1'b1;
                status_q.input_overvoltage_status_bit <= 1'b1;
                status_q.alert <= 1'b1;
            end
            if (uv_rise) begin
                status_q.none_above <= 1'b1;
                status_q.input_flag <= 1'b1;
                status_q.input_undervoltage_warning_bit <= 1'b1;
                status_q.alert <= 1'b1;
            end
            if (wr_err) begin
                status_q.cml_data <= 1'b1;
                status_q.alert <= 1'b1;
            end
        end
    end

    // half-millisecond tick paces turn-on delay and restart wait
    assign tick = pre_q == 16'(HALF_MS_CYCLES - 1);
    always_ff @(posedge ref_clk) begin
        if (sys_rst || tick) begin
            pre_q <= 16'h0000;
        end else begin
            pre_q <= pre_q + 16'h0001;
        end
    end

    ivfc_pwm_delay u_pwm_delay (
        .pwm_clk(pwm_clk),
        .sys_rst(sys_rst),
        .req(dly_req_q),
        .cycles(dly_cnt_q),
        .done_q(dly_done_raw)
    );

    ivfc_sync #(.WIDTH(1)) u_done_sync (
        .clk(ref_clk),
        .d(dly_done_raw),
        .q(dly_done_s)
    );

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_q <= ST_OFF;
            attempts_q <= 3'h0;
            wait_q <= 12'h000;
            dly_req_q <= 1'b0;
            dly_cnt_q <= DLY_SHORT;
            switching_q <= 1'b0;
            ramp_start_q <= 1'b0;
            latched_off_q <= 1'b0;
        end else begin
            ramp_start_q <= 1'b0;
            if (tick && wait_q != 12'h000) begin
                wait_q <= wait_q - 12'h001;
            end
            if (!enable) begin
                st_q <= ST_OFF;
                attempts_q <= 3'h0;
                dly_req_q <= 1'b0;
                switching_q <= 1'b0;
                latched_off_q <= 1'b0;
            end else begin
                case (st_q)
                    ST_OFF: begin
                        if (!ov_present) begin
                            st_q <= ST_TON;
                            wait_q <= {3'h0, ton_q8[TON_STEP_SHIFT+8:TON_STEP_SHIFT]};
                        end
                    end
                    ST_TON: begin
                        if (wait_q == 12'h000) begin
                            st_q <= ST_ON;
                            switching_q <= 1'b1;
                            ramp_start_q <= 1'b1;
                            attempts_q <= 3'h0;
                        end
                    end
                    ST_ON: begin
                        if (ov_present && act == ACT_DELAYED && !dly_done_s) begin
                            st_q <= ST_DLY;
                            dly_req_q <= 1'b1;
                            dly_cnt_q <= dly_cycles(dcode);
                        end else if (ov_present && act == ACT_IMMEDIATE) begin
                            switching_q <= 1'b0;
                            st_q <= (retry == 3'h0) ? ST_LATCH : ST_RESTART_WAIT_PERIOD;
                            latched_off_q <= retry == 3'h0;
                            wait_q <= restart_wait_period_ticks;
                        end
                    end
                    ST_DLY: begin
                        if (dly_done_s) begin
                            dly_req_q <= 1'b0;
                            if (ov_present) begin
                                switching_q <= 1'b0;
                                st_q <= (retry == 3'h0) ? ST_LATCH : ST_RESTART_WAIT_PERIOD;
                                latched_off_q <= retry == 3'h0;
                                wait_q <= restart_wait_period_ticks;
                            end else begin
                                st_q <= ST_ON;
                            end
                        end
                    end
                    ST_RESTART_WAIT_PERIOD: begin
                        if (wait_q == 12'h000) begin
                            // attempts under overvoltage count unless retry is RETRY_FOREVER, and stay dark
                            if (retry != RETRY_FOREVER) begin
                                attempts_q <= attempts_q + 3'h1;
                            end
                            if (retry != RETRY_FOREVER && attempts_q + 3'h1 >= retry) begin
                                if (ov_present) begin
                                    st_q <= ST_LATCH;
                                    latched_off_q <= 1'b1;
                                end else begin
                                    st_q <= ST_TON;
                                end
                            end else if (ov_present) begin
                                wait_q <= restart_wait_period_ticks;
                            end else begin
                                st_q <= ST_TON;
                            end
                        end
                    end
                    ST_LATCH: begin
                        latched_off_q <= 1'b1;
                    end
                    default: begin
                        st_q <= ST_OFF;
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_ov_write_bad;
        wr_ov && !wr_ov_ok && !restore_q;
    endsequence
    sequence s_resp_write_bad;
        wr_resp && !wr_resp_ok && !restore_q;
    endsequence

    chk_ov_status: assert property (ov_rise |=> status_q.input_overvoltage_status_bit && status_q.alert)
        else $error("overvoltage did not set status");
    chk_uv_status: assert property (uv_rise |=> status_q.input_undervoltage_warning_bit && status_q.none_above)
        else $error("undervoltage warning did not set status");
    chk_ov_reject: assert property (s_ov_write_bad |=> $stable(ov_lim_q) && rsp_q.err)
        else $error("bad threshold write was applied");
    chk_resp_reject: assert property (s_resp_write_bad |=> $stable(resp_q)
                                      ##0 status_q.cml_data)
        else $error("bad response write was applied");
    chk_uv_floor: assert property (!restore_q |=> lin_q8(uv_lim_q) >= V_MIN_Q8
                                   || !uv_programmed_q)
        else $error("warning threshold fell below floor");
    chk_no_start: assert property (st_q == ST_OFF && ov_present |=> st_q != ST_TON)
        else $error("start-up despite overvoltage");
    chk_latch_zero: assert property (st_q == ST_ON && enable && ov_present
                                     && act == ACT_IMMEDIATE && retry == 3'h0
                                     |=> st_q == ST_LATCH ##1 latched_off_q)
        else $error("no latch-off with zero retries");
    chk_ignore_run: assert property (st_q == ST_ON && enable && act == ACT_IGNORE
                                     |=> switching_q)
        else $error("ignore mode stopped switching");
    chk_ton_reject: assert property (wr_ton && !wr_ton_ok && !restore_q
                                     |=> $stable(ton_q) && rsp_q.err)
        else $error("bad turn-on delay write was applied");
    chk_dly_bound: assert property (st_q == ST_DLY && !dly_done_s && enable
                                    |-> ##[1:60] (st_q != ST_DLY))
        else $error("delayed shutdown never resolved");
endmodule

// ==== common/ivfc_pkg.sv ====
// constants, carriers and state codes of the input-rail fault command bank
// Function
// - code 55h holds overvoltage threshold, drives fault
// - threshold 5 V to 22 V, quarter-volt steps
// - restore rounds threshold to nearest supported step
// - limit words: 5-bit exponent, 11-bit mantissa
// - overvoltage sets status bits, alerts host
// - action field: ignore, delayed, immediate; 11b rejected
// - delayed mode counts switching cycles, then shuts down
// - retry zero latches off after shutdown
// - retries 1-6 wait, counted, then latch
// - delay code sets cycles and wait multiple
// - overvoltage at enable blocks start-up
// - code 58h holds undervoltage warning threshold
// - undervoltage warning detected on the single input reading
// - undervoltage warning sets status bits, alerts
// - warning default 2.5 V, accepts 5-22 V
// - once above 5 V, never below; restore loads nvm_uv_man without the floor check
// - bad response writes ignored, error flagged
// - code 60h holds turn-on delay
// - turn-on delay 0-127.5 ms, half-ms steps, rounded
// - turn-on delay exponent resets to 11111b
package ivfc_pkg;
    localparam logic [7:0] CODE_OV_LIMIT = 8'h55;
    localparam logic [7:0] CODE_OV_RESP = 8'h56;
    localparam logic [7:0] CODE_UV_LIMIT = 8'h58;
    localparam logic [7:0] CODE_TURN_ON_DELAY = 8'h60;
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam int MAN_MSB = 10;
    localparam int ACT_MSB = 7;
    localparam int ACT_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DLY_MSB = 2;
    localparam logic [4:0] EXP_QUARTER = 5'h1E;
    localparam logic [4:0] EXP_HALF = 5'h1F;
    localparam logic [10:0] UV_RESET_MAN = 11'h00A;
    localparam int FRAC_BITS = 8;
    localparam logic signed [31:0] V_MIN_Q8 = 32'sh0000_0500;
    localparam logic signed [31:0] V_MAX_Q8 = 32'sh0000_1600;
    localparam logic signed [31:0] TON_MAX_Q8 = 32'sh0000_7F80;
    localparam int OV_STEP_SHIFT = 6;
    localparam int TON_STEP_SHIFT = 7;
    localparam logic signed [31:0] OV_MIN_STEPS = 32'sh0000_0014;
    localparam logic signed [31:0] OV_MAX_STEPS = 32'sh0000_0058;
    localparam logic signed [31:0] TON_MAX_STEPS = 32'sh0000_00FF;
    localparam logic [1:0] ACT_IGNORE = 2'h0;
    localparam logic [1:0] ACT_DELAYED = 2'h1;
    localparam logic [1:0] ACT_IMMEDIATE = 2'h2;
    localparam logic [1:0] ACT_INVALID = 2'h3;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    localparam logic [3:0] DLY_SHORT = 4'h3;
    localparam logic [3:0] DLY_MID = 4'h5;
    localparam logic [3:0] DLY_LONG = 4'h9;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TON_STEP_NS = 500000;
    localparam int TON_STEP_CYCLES = TON_STEP_NS / CLK_PERIOD_NS;

    typedef enum logic [5:0] {
        ST_OFF = 6'b000001,
        ST_TON = 6'b000010,
        ST_ON = 6'b000100,
        ST_DLY = 6'b001000,
        ST_RESTART_WAIT_PERIOD = 6'b010000,
        ST_LATCH = 6'b100000
    } ivfc_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } ivfc_cmd_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [15:0] rdata;
    } ivfc_rsp_t;

    typedef struct packed {
        logic none_above;
        logic input_flag;
        logic input_overvoltage_status_bit;
        logic input_undervoltage_warning_bit;
        logic cml_data;
        logic alert;
    } ivfc_stat_t;
endpackage

// ==== core/ivfc_sync.sv ====
// two-flop level synchroniser
`timescale 1ns/1ns
module ivfc_sync #(
    parameter int WIDTH = 1
) (
    // clock
    input wire logic clk,
    // data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk) begin
        meta_q <= d;
        q <= meta_q;
    end
endmodule

// ==== core/ivfc_pwm_delay.sv ====
// switching-cycle counter for delayed shutdown, on the switching clock
`timescale 1ns/1ns
module ivfc_pwm_delay (
    // switching clock and reset from the control domain
    input wire logic pwm_clk,
    input wire logic sys_rst,
    // request handshake
    input wire logic req,
    input wire logic [3:0] cycles,
    output logic done_q
);
    logic rst_s;
    logic req_s;
    logic [3:0] cnt_q;

    ivfc_sync #(.WIDTH(2)) u_sync (
        .clk(pwm_clk),
        .d({sys_rst, req}),
        .q({rst_s, req_s})
    );

    // cycles is held steady by the sender while req is high
    always_ff @(posedge pwm_clk) begin
        if (rst_s || !req_s) begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
        end else if (!done_q) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q + 4'h1 >= cycles) begin
                done_q <= 1'b1;
            end
        end
    end
endmodule

// ==== sim/ivfc_host.sv ====
// host model issuing one register command at a time
`timescale 1ns/1ns
module ivfc_host (
    // clock
    input wire logic ref_clk,
    // command port
    output ivfc_pkg::ivfc_cmd_t cmd,
    input wire ivfc_pkg::ivfc_rsp_t rsp_q
);
    import ivfc_pkg::*;
    logic [15:0] rd;
    logic er;
    logic got;
    initial cmd = '0;
    // request held through its taking edge; answer waited on, bounded
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(negedge ref_clk);
        cmd <= '{1'b1, w, c, d};
        @(negedge ref_clk);
        cmd.valid <= 1'b0;
        got = 1'b0;
        repeat (3) begin
            if (!got && rsp_q.valid === 1'b1) begin
                got = 1'b1;
                rd = rsp_q.rdata;
                er = rsp_q.err;
            end
            if (!got) @(negedge ref_clk);
        end
        if (!got) er = 1'bx;
    endtask
endmodule

// ==== sim/ivfc_tb_top.sv ====
// self-checking bench of the input-rail fault command bank
`timescale 1ns/1ns
module ivfc_tb_top;
    import ivfc_pkg::*;
    logic ref_clk = 0, pwm_clk = 0, sys_rst = 1, nvm_restore = 0;
    logic enable = 0, clear_faults = 0, switching_q, ramp_start_q, latched_off_q, h;
    logic [10:0] nvm_ov_man = 11'd10, nvm_uv_man = 11'd40, nvm_ton_man = 11'd6;
    logic [7:0] nvm_resp = 8'h80, rise_ticks = 8'h02;
    logic [15:0] vin_meas = 16'h0A00;
    ivfc_cmd_t cmd;
    ivfc_rsp_t rsp_q;
    ivfc_stat_t status_q;
    int fail_count = 0, total_checks = 0, cycles = 0, m;
    always #25 ref_clk = ~ref_clk;
    always #80 pwm_clk = ~pwm_clk;
    ivfc_host i_ivfc_host (.ref_clk(ref_clk), .cmd(cmd), .rsp_q(rsp_q));
    ivfc_top #(.HALF_MS_CYCLES(4)) i_ivfc_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .pwm_clk(pwm_clk), .cmd(cmd), .rsp_q(rsp_q), .nvm_restore(nvm_restore),
        .nvm_ov_man(nvm_ov_man), .nvm_uv_man(nvm_uv_man), .nvm_ton_man(nvm_ton_man),
        .nvm_resp(nvm_resp), .vin_meas(vin_meas), .enable(enable),
        .rise_ticks(rise_ticks), .clear_faults(clear_faults), .switching_q(switching_q),
        .ramp_start_q(ramp_start_q), .latched_off_q(latched_off_q), .status_q(status_q));
    function automatic logic [15:0] lw(input logic [4:0] e, input int v);
        return {e, v[10:0]};
    endfunction
    task automatic chk(input logic ok, input string s);
        total_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, s);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
        i_ivfc_host.xfer(1'b1, c, d);
        chk(i_ivfc_host.er === e, "write response");
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] x);
        i_ivfc_host.xfer(1'b0, c, 16'h0000);
        chk(i_ivfc_host.rd === x && i_ivfc_host.er === 1'b0, "read value");
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // s 0 waits for the ramp pulse, 1 for latch-off
    task automatic waitfor(input int s, input int lim, output logic hit);
        hit = 1'b0;
        repeat (lim) begin
            @(negedge ref_clk);
            if ((s == 0 ? ramp_start_q : latched_off_q) === 1'b1) hit = 1'b1;
        end
    endtask
    // off, faults cleared, rail back to 10 V
    task automatic idle();
        enable = 0;
        vin_meas = 16'h0A00;
        clear_faults = 1;
        cyc(1);
        clear_faults = 0;
        cyc(2);
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(30));
        cyc(3);
        sys_rst = 0;
        cyc(2);
        rd(CODE_OV_LIMIT, lw(EXP_QUARTER, 20));
        rd(CODE_TURN_ON_DELAY, lw(EXP_HALF, 6));
        rd(CODE_UV_LIMIT, lw(EXP_QUARTER, 40));
        rd(CODE_OV_RESP, 16'h0080);
        repeat (8) begin
            m = 20 + $urandom % 69;
            wr(CODE_OV_LIMIT, lw(EXP_QUARTER, m), 1'b0);
            rd(CODE_OV_LIMIT, lw(EXP_QUARTER, m));
        end
        wr(CODE_OV_LIMIT, lw(EXP_QUARTER, 19), 1'b1);
        wr(CODE_OV_LIMIT, lw(EXP_QUARTER, 89), 1'b1);
        chk(status_q.cml_data === 1'b1 && status_q.alert === 1'b1, "data error flag");
        wr(CODE_OV_RESP, 16'h00C0, 1'b1);
        rd(CODE_OV_RESP, 16'h0080);
        wr(CODE_UV_LIMIT, lw(EXP_QUARTER, 19), 1'b1);
        wr(CODE_TURN_ON_DELAY, lw(EXP_HALF, 256), 1'b1);
        wr(CODE_TURN_ON_DELAY, lw(EXP_HALF, 255), 1'b0);
        nvm_ov_man = 11'd100;
        nvm_restore = 1;
        cyc(1);
        nvm_restore = 0;
        rd(CODE_OV_LIMIT, lw(EXP_QUARTER, 88));
        rd(CODE_TURN_ON_DELAY, lw(EXP_HALF, 6));
        idle();
        wr(CODE_OV_LIMIT, lw(EXP_QUARTER, 48), 1'b0);
        enable = 1;
        waitfor(0, 20, h);
        chk(!h, "ramp too early");
        waitfor(0, 20, h);
        chk(h && switching_q === 1'b1, "no ramp");
        vin_meas = 16'h0D00;
        cyc(2);
        chk(switching_q === 1'b0 && latched_off_q === 1'b1, "no latch-off");
        chk(status_q.input_overvoltage_status_bit && status_q.none_above && status_q.input_flag
            && status_q.alert, "ov status");
        idle();
        wr(CODE_OV_RESP, 16'h0000, 1'b0);
        vin_meas = 16'h0D00;
        enable = 1;
        waitfor(0, 60, h);
        chk(!h, "start under fault");
        idle();
        enable = 1;
        waitfor(0, 60, h);
        vin_meas = 16'h0D00;
        cyc(20);
        chk(h && switching_q === 1'b1, "ignore stopped");
        wr(CODE_OV_RESP, 16'h0045, 1'b0);
        cyc(20);
        chk(switching_q === 1'b1, "delay too short");
        waitfor(1, 40, h);
        chk(h && switching_q === 1'b0, "delayed stop");
        for (int r = 2; r < 8; r += 5) begin
            idle();
            wr(CODE_OV_RESP, 16'h0080 | 16'(r << 3), 1'b0);
            enable = 1;
            waitfor(0, 60, h);
            vin_meas = 16'h0D00;
            cyc(4);
            chk(latched_off_q === 1'b0, "latched early");
            waitfor(1, 300, h);
            chk(h === (r != 7), "retry latch");
        end
        vin_meas = 16'h0A00;
        waitfor(0, 100, h);
        chk(h, "no restart");
        idle();
        vin_meas = 16'h0400;
        cyc(3);
        chk(status_q.input_undervoltage_warning_bit && status_q.none_above && status_q.input_flag
            && status_q.alert, "uv status");
        report_and_stop();
    end
endmodule
